// [design/mfsd_measure.v]
// Measurement sequencer, result register, status code and diagnostics.
// Assumes config and sample inputs come from logic on CLOCK; the two
// command strobes come from the serial front end and are resynchronised.
//
// Contract
// R1: Capacitance interval follows resolution and rate table
// R2: Temperature interval follows resolution and rate table
// R3: One temperature per six captures, capture follows
// R4: Early fetch repeats result with stale code
// R5: Ready rises when a new result lands
// R6: Sleep mode converts only on a request
// R7: No density output in sleep; alarms need serial
// R8: Wake runs temperature, capacitance, then correction
// R9: Update results and alarms before powering down
// R10: SPI needs a fetch before next request
// R11: After fetch in sleep stay powered down
// R12: Host waits full conversion before polling status
// R13: Status code in top bits of high byte
// R14: Codes: 00 fresh, 01 stale, 10 command
// R15: Fetch before first result reads stale
// R16: Any fault saturates both results to 3FFF
// R17: Any fault rails both density outputs high
// R18: Config fault checked at boot and wake, permanent
// R19: Other faults reported with the next update
// R20: Parity error at config load is permanent
// R21: RAM parity, double-bit, overflow flag transient
// R22: Fetched flag cleared on write, set on fetch
`timescale 1ns/1ps
`include "mfsd_defines.vh"
module mfsd_measure #(
  parameter TICK_CYCLES = `MFSD_TICK_NS / `MFSD_CLK_NS
) (
  input wire CLOCK,
  input wire SRST,
  input wire SLEEP_MODE,
  input wire SPI_SELECT,
  input wire DENSITY_SELECT,
  input wire COMMAND_MODE,
  input wire [1:0] RES_SEL,
  input wire [1:0] RATE_SEL,
  input wire CONVERSION_MULTIPLIER_EIGHT,
  input wire RESULT_FETCH_CMD,
  input wire CONVERT_REQUEST_CMD,
  input wire [13:0] CAP_SAMPLE,
  input wire [13:0] TEMP_SAMPLE,
  input wire CFG_PARITY_ERR,
  input wire RAM_PARITY_ERR,
  input wire DOUBLE_BIT_ERROR_FLAG,
  input wire MATH_OVERFLOW,
  output reg [13:0] CAP_RESULT,
  output reg [13:0] TEMP_RESULT,
  output reg [1:0] STATUS_CODE,
  output reg [7:0] FETCH_HIGH_BYTE,
  output reg READY,
  output reg CORE_POWERED,
  output reg ALARM_ENABLE,
  output reg ALARM_UPDATE,
  output wire CAP_DENSITY_OUT,
  output wire TEMP_DENSITY_OUT
);
  localparam [3:0] ST_DOWN = 4'b0001;
  localparam [3:0] ST_TEMP = 4'b0010;
  localparam [3:0] ST_CAP = 4'b0100;
  localparam [3:0] ST_WRITE = 4'b1000;

  // Capacitance period in ticks; also used for the sleep cycle at code 00
  function [12:0] cap_ticks;
    input [1:0] res;
    input [1:0] rate;
    reg [12:0] base;
    begin
      base = `MFSD_CAP_T8;
      if (res == 2'h1) base = `MFSD_CAP_T10;
      else if (res == 2'h2) base = `MFSD_CAP_T12;
      else if (res == 2'h3) base = `MFSD_CAP_T14;
      if (rate == 2'h1) cap_ticks = base + `MFSD_RATE_T1;
      else if (rate == 2'h2) cap_ticks = base + `MFSD_RATE_T2;
      else if (rate == 2'h3) cap_ticks = base + `MFSD_RATE_T3;
      else cap_ticks = base;
    end
  endfunction

  function [12:0] tmp_ticks;
    input [1:0] res;
    begin
      if (res == 2'h1) tmp_ticks = `MFSD_TMP_T10;
      else if (res == 2'h2) tmp_ticks = `MFSD_TMP_T12;
      else if (res == 2'h3) tmp_ticks = `MFSD_TMP_T14;
      else tmp_ticks = `MFSD_TMP_T8;
    end
  endfunction

  // Command strobes cross from the serial clock; edges found after sync
  reg fetch_s1_q, fetch_s2_q, fetch_s3_q;
  reg req_s1_q, req_s2_q, req_s3_q;
  wire fetch_evt;
  wire req_evt;

  always @(posedge CLOCK) begin
    if (SRST) begin
      fetch_s1_q <= 1'b0;
      fetch_s2_q <= 1'b0;
      fetch_s3_q <= 1'b0;
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end else begin
      fetch_s1_q <= RESULT_FETCH_CMD;
      fetch_s2_q <= fetch_s1_q;
      fetch_s3_q <= fetch_s2_q;
      req_s1_q <= CONVERT_REQUEST_CMD;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end

  assign fetch_evt = fetch_s2_q & ~fetch_s3_q;
  assign req_evt = req_s2_q & ~req_s3_q;

  // 0.05 ms tick from the system clock
  reg [15:0] div_q;
  wire tick;
  assign tick = (div_q == TICK_CYCLES[15:0] - 16'h0001);

  always @(posedge CLOCK) begin
    if (SRST || tick) div_q <= 16'h0000;
    else div_q <= div_q + 16'h0001;
  end

  reg [3:0] state_q;
  reg [12:0] left_q;
  reg [2:0] caps_q;
  reg did_temp_q;
  reg boot_q;
  reg cfg_err_q;
  reg tran_err_q;
  reg fault_q;
  reg fetched_q;
  wire phase_end;
  wire sleep_ok;
  wire new_fetched;

  assign phase_end = tick && (left_q == 13'h0001);
  // Only the multiplier-eight timing is built
  wire [1:0] run_rate;
  assign run_rate = SLEEP_MODE ? 2'h0 : RATE_SEL;
  // A new SPI request is ignored until the last result was fetched
  assign sleep_ok = !SPI_SELECT || fetched_q; // [R10]

  always @(posedge CLOCK) begin
    if (SRST) begin
      state_q <= ST_DOWN;
      left_q <= 13'h0001;
      caps_q <= 3'h0;
      did_temp_q <= 1'b0;
      boot_q <= 1'b1;
      cfg_err_q <= 1'b0;
      tran_err_q <= 1'b0;
      CORE_POWERED <= 1'b0;
      ALARM_UPDATE <= 1'b0;
    end else begin
      ALARM_UPDATE <= 1'b0;
      boot_q <= 1'b0;
      // Config check at boot and each wake; never cleared once set
      if ((boot_q || (state_q == ST_DOWN && req_evt)) && CFG_PARITY_ERR)
        cfg_err_q <= 1'b1; // [R18] [R20]
      if (state_q != ST_DOWN && state_q != ST_WRITE &&
          (RAM_PARITY_ERR || DOUBLE_BIT_ERROR_FLAG || MATH_OVERFLOW))
        tran_err_q <= 1'b1; // [R21]
      case (state_q)
        ST_DOWN: begin
          if (boot_q && !SLEEP_MODE) begin
            state_q <= ST_TEMP;
            left_q <= tmp_ticks(RES_SEL);
            tran_err_q <= 1'b0;
            CORE_POWERED <= 1'b1;
          end else if (!SLEEP_MODE) begin
            state_q <= ST_TEMP;
            left_q <= tmp_ticks(RES_SEL);
            tran_err_q <= 1'b0;
            CORE_POWERED <= 1'b1;
          end else if (req_evt && sleep_ok) begin
            // Wake only on a request: temperature, then capacitance
            state_q <= ST_TEMP; // [R6] [R8] [R11]
            left_q <= tmp_ticks(RES_SEL);
            tran_err_q <= 1'b0;
            CORE_POWERED <= 1'b1;
          end
        end
        ST_TEMP: begin
          if (phase_end) begin
            // Capacitance always follows a temperature conversion
            state_q <= ST_CAP; // [R3] [R8]
            left_q <= cap_ticks(RES_SEL, run_rate); // [R2]
            did_temp_q <= 1'b1;
          end
        end
        ST_CAP: begin
          if (phase_end) state_q <= ST_WRITE;
          else if (tick) left_q <= left_q - 13'h0001;
        end
        ST_WRITE: begin
          ALARM_UPDATE <= 1'b1; // [R9]
          did_temp_q <= 1'b0;
          tran_err_q <= 1'b0;
          if (SLEEP_MODE) begin
            state_q <= ST_DOWN; // [R9] [R11]
            CORE_POWERED <= 1'b0;
            caps_q <= 3'h0;
          end else if (caps_q == `MFSD_CAP_PER_TMP) begin
            state_q <= ST_TEMP; // [R3] [R2]
            left_q <= tmp_ticks(RES_SEL);
            caps_q <= 3'h0;
          end else begin
            // Period counts from the previous result to the next
            state_q <= ST_CAP; // [R1]
            left_q <= cap_ticks(RES_SEL, run_rate);
            caps_q <= caps_q + 3'h1;
          end
        end
        default: state_q <= ST_DOWN;
      endcase
      if (state_q == ST_TEMP && !phase_end && tick)
        left_q <= left_q - 13'h0001;
    end
  end

  // Write into the output register wins over a fetch in the same cycle
  wire writing;
  assign writing = (state_q == ST_WRITE);
  assign new_fetched = writing ? 1'b0 : (fetch_evt ? 1'b1 : fetched_q);
  // Latched or still present at the write; one term for results and rails
  wire cyc_fault;
  assign cyc_fault = cfg_err_q | tran_err_q | RAM_PARITY_ERR |
                     DOUBLE_BIT_ERROR_FLAG | MATH_OVERFLOW;
  // Last real temperature, so a clean cycle drops an old 3FFF
  reg [13:0] temp_keep_q;

  always @(posedge CLOCK) begin
    if (SRST) begin
      fetched_q <= 1'b1; // [R15]
      fault_q <= 1'b0;
      CAP_RESULT <= 14'h0000;
      TEMP_RESULT <= 14'h0000;
      temp_keep_q <= 14'h0000;
      STATUS_CODE <= `MFSD_ST_STALE;
      FETCH_HIGH_BYTE <= {`MFSD_ST_STALE, 6'h00};
      READY <= 1'b0;
      ALARM_ENABLE <= 1'b0;
    end else begin
      fetched_q <= new_fetched; // [R22] [R4]
      if (writing) begin
        // Faults of this cycle appear with this update
        fault_q <= cyc_fault; // [R19]
        if (cyc_fault) begin
          CAP_RESULT <= `MFSD_SAT; // [R16]
          TEMP_RESULT <= `MFSD_SAT; // [R16]
        end else begin
          CAP_RESULT <= CAP_SAMPLE;
          if (did_temp_q) begin
            TEMP_RESULT <= TEMP_SAMPLE;
            temp_keep_q <= TEMP_SAMPLE;
          end else begin
            TEMP_RESULT <= temp_keep_q;
          end
        end
      end else if (cfg_err_q) begin
        // Permanent fault shows even before any new cycle
        fault_q <= 1'b1;
        CAP_RESULT <= `MFSD_SAT; // [R16] [R18]
        TEMP_RESULT <= `MFSD_SAT;
      end
      READY <= !new_fetched; // [R5]
      if (COMMAND_MODE) STATUS_CODE <= `MFSD_ST_CMD; // [R14]
      else if (new_fetched) STATUS_CODE <= `MFSD_ST_STALE; // [R4] [R14]
      else STATUS_CODE <= `MFSD_ST_VALID; // [R14]
      FETCH_HIGH_BYTE[`MFSD_STATUS_MSB:`MFSD_STATUS_LSB] <=
        COMMAND_MODE ? `MFSD_ST_CMD :
        (new_fetched ? `MFSD_ST_STALE : `MFSD_ST_VALID); // [R13]
      FETCH_HIGH_BYTE[5:0] <= writing ?
        (cyc_fault ? 6'h3F : CAP_SAMPLE[13:8]) :
        (cfg_err_q ? 6'h3F : CAP_RESULT[13:8]);
      // Alarms in sleep need a serial port to carry requests
      ALARM_ENABLE <= !SLEEP_MODE || !DENSITY_SELECT; // [R7]
    end
  end

  // Density output is off in sleep; no request could ever reach it
  wire dens_en;
  assign dens_en = DENSITY_SELECT && !SLEEP_MODE; // [R7]

  mfsd_density u_cap_dens (
    .clk(CLOCK),
    .srst(SRST),
    .enable(dens_en),
    .rail(fault_q), // [R17]
    .value(CAP_RESULT),
    .dout(CAP_DENSITY_OUT)
  );

  mfsd_density u_temp_dens (
    .clk(CLOCK),
    .srst(SRST),
    .enable(dens_en),
    .rail(fault_q), // [R17]
    .value(TEMP_RESULT),
    .dout(TEMP_DENSITY_OUT)
  );
endmodule // mfsd_measure

// [design/mfsd_defines.vh]
// Constants for the measurement fetch, status and diagnostic block.
// Included by the block's design files; definitions only.
`ifndef MFSD_DEFINES_VH
`define MFSD_DEFINES_VH

// Clock period and the timing tick, both in ns
`define MFSD_CLK_NS 50
`define MFSD_TICK_NS 50000

// Capacitance period at update code 00, in 0.05 ms ticks (2.80/9.60/...)
`define MFSD_CAP_T8 13'h0038
`define MFSD_CAP_T10 13'h00C0
`define MFSD_CAP_T12 13'h02D8
`define MFSD_CAP_T14 13'h0B48
// Extra period added by update codes 01, 10, 11 (5, 25, 125 ms)
`define MFSD_RATE_T1 13'h0064
`define MFSD_RATE_T2 13'h01F4
`define MFSD_RATE_T3 13'h09C4
// Temperature conversion plus correction, in ticks (0.55/1.40/4.75/18.25)
`define MFSD_TMP_T8 13'h000B
`define MFSD_TMP_T10 13'h001C
`define MFSD_TMP_T12 13'h005F
`define MFSD_TMP_T14 13'h016D

// Capacitance conversions per temperature conversion, minus one
`define MFSD_CAP_PER_TMP 3'h5

// Fetch status codes
`define MFSD_ST_VALID 2'h0
`define MFSD_ST_STALE 2'h1
`define MFSD_ST_CMD 2'h2

// Saturated diagnostic result and field positions
`define MFSD_SAT 14'h3FFF
`define MFSD_STATUS_MSB 7
`define MFSD_STATUS_LSB 6

`endif

// [design/mfsd_density.v]
// First-order density modulator for one result channel.
// Assumes a value that is stable between output register updates.
`timescale 1ns/1ps
module mfsd_density (
  input wire clk,
  input wire srst,
  input wire enable,
  input wire rail,
  input wire [13:0] value,
  output reg dout
);
  reg [13:0] acc_q;
  wire [14:0] sum;

  assign sum = {1'b0, acc_q} + {1'b0, value};

  always @(posedge clk) begin
    if (srst || !enable) begin
      acc_q <= 14'h0000;
      dout <= 1'b0;
    end else if (rail) begin
      acc_q <= 14'h0000;
      dout <= 1'b1;
    end else begin
      acc_q <= sum[13:0];
      dout <= sum[14];
    end
  end
endmodule // mfsd_density

// [tb/mfsd_host.sv]
// Host model: pulses the fetch and request pins from its link clock.
// Assumes the bench calls pulse once at a time, in a legal order.
`timescale 1ns/1ps
module mfsd_host (
  input wire lk,
  output logic [1:0] cmd
);
  initial cmd = 2'h0;
  // Index 0 fetches, 1 requests; pins are quiet between commands
  task pulse(input int k);
    begin
      @(posedge lk);
      cmd[k] <= 1'b1;
      repeat (2) @(posedge lk);
      cmd[k] <= 1'b0;
      repeat (2) @(posedge lk);
    end
  endtask
endmodule // mfsd_host

// [tb/mfsd_measure_properties.sv]
// Port checker for the measurement block: codes, Ready, sleep, faults.
// Assumes raw samples below 3FFF so saturation means a fault.
`timescale 1ns/1ps
module mfsd_props #(
  parameter TICK_CYCLES = 1000
) (
  input wire CLOCK,
  input wire SRST,
  input wire SLEEP_MODE,
  input wire DENSITY_SELECT,
  input wire COMMAND_MODE,
  input wire CONVERT_REQUEST_CMD,
  input wire [13:0] CAP_RESULT,
  input wire [13:0] TEMP_RESULT,
  input wire [1:0] STATUS_CODE,
  input wire [7:0] FETCH_HIGH_BYTE,
  input wire READY,
  input wire CORE_POWERED,
  input wire ALARM_ENABLE,
  input wire ALARM_UPDATE,
  input wire CAP_DENSITY_OUT,
  input wire TEMP_DENSITY_OUT
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SRST);
  a_code_legal: assert property (STATUS_CODE != 2'h3)
    else $error("Unused status code");
  a_byte_pack: assert property (
    FETCH_HIGH_BYTE == {STATUS_CODE, CAP_RESULT[13:8]})
    else $error("High byte packing wrong");
  a_ready_fresh: assert property (
    $rose(READY) && !COMMAND_MODE |-> STATUS_CODE == 2'h0)
    else $error("Ready rose without fresh code");
  a_ready_drop: assert property (
    $fell(READY) && !COMMAND_MODE |-> STATUS_CODE == 2'h1)
    else $error("Ready fell without stale code");
  a_sleep_quiet: assert property (
    (SLEEP_MODE && !CORE_POWERED && !CONVERT_REQUEST_CMD) [*5]
    |=> !CORE_POWERED)
    else $error("Core woke without request");
  a_sleep_down: assert property (
    ALARM_UPDATE && SLEEP_MODE |-> ##[0:2] (READY && !CORE_POWERED))
    else $error("No power down after sleep write");
  a_sat_pair: assert property (
    (CAP_RESULT == 14'h3FFF) == (TEMP_RESULT == 14'h3FFF))
    else $error("Only one result saturated");
  a_rail_high: assert property (
    (DENSITY_SELECT && !SLEEP_MODE && CAP_RESULT == 14'h3FFF) [*3]
    |-> CAP_DENSITY_OUT && TEMP_DENSITY_OUT)
    else $error("Density outputs not railed");
  a_alarm_off: assert property (
    (SLEEP_MODE && DENSITY_SELECT) [*2] |-> !ALARM_ENABLE)
    else $error("Alarms on in sleep without serial");
endmodule // mfsd_props

bind mfsd_measure mfsd_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .CLOCK, .SRST, .SLEEP_MODE, .DENSITY_SELECT, .COMMAND_MODE,
  .CONVERT_REQUEST_CMD, .CAP_RESULT, .TEMP_RESULT, .STATUS_CODE,
  .FETCH_HIGH_BYTE, .READY, .CORE_POWERED, .ALARM_ENABLE, .ALARM_UPDATE,
  .CAP_DENSITY_OUT, .TEMP_DENSITY_OUT);

// [tb/testbench.sv]
// Self-checking bench for the measurement block with a host model.
// Assumes the block's tick is shortened to two clocks.
`timescale 1ns/1ps
module testbench;
  localparam int TK = 2;
  logic clk, lk, srst, sl, spi, ds, cm, cfg, rdy, pwr, aen, aup, cd, td;
  logic [1:0] res, rate, st;
  logic [2:0] flt;
  logic [7:0] hb;
  logic [13:0] cs, ts, cr, tr, tx;
  logic tv;
  wire [1:0] cmd;
  int err_total, total_checks, cyc, last, g, e, t1, t2, nw;
  // Periods in 0.05 ms ticks; five captures then one after a temperature
  int capt[4] = '{56, 192, 728, 2888};
  int tmpx[4] = '{11, 28, 95, 365};
  int ratx[4] = '{0, 100, 500, 2500};
  mfsd_host host (.lk(lk), .cmd(cmd));
  mfsd_measure #(.TICK_CYCLES(TK)) dut (.CLOCK(clk), .SRST(srst),
    .SLEEP_MODE(sl), .SPI_SELECT(spi), .DENSITY_SELECT(ds),
    .COMMAND_MODE(cm), .RES_SEL(res), .RATE_SEL(rate),
    .CONVERSION_MULTIPLIER_EIGHT(1'b1), .RESULT_FETCH_CMD(cmd[0]),
    .CONVERT_REQUEST_CMD(cmd[1]), .CAP_SAMPLE(cs), .TEMP_SAMPLE(ts),
    .CFG_PARITY_ERR(cfg), .RAM_PARITY_ERR(flt[0]),
    .DOUBLE_BIT_ERROR_FLAG(flt[1]), .MATH_OVERFLOW(flt[2]),
    .CAP_RESULT(cr), .TEMP_RESULT(tr), .STATUS_CODE(st),
    .FETCH_HIGH_BYTE(hb), .READY(rdy), .CORE_POWERED(pwr),
    .ALARM_ENABLE(aen), .ALARM_UPDATE(aup), .CAP_DENSITY_OUT(cd),
    .TEMP_DENSITY_OUT(td));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    lk = 1'b0;
    #7;
    forever #200 lk = ~lk;
  end
  // Cycle count for intervals; the ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (aup === 1'b1)
      nw <= nw + 1;
    if (cyc == 60000) begin
      err_total++;
      results;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      total_checks++;
      if (got !== exp) begin
        err_total++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wup;
    begin
      do @(negedge clk); while (aup !== 1'b1);
      g = cyc - last;
      last = cyc;
    end
  endtask
  task nxt;
    begin
      @(posedge clk);
      cs <= 14'($urandom % 16383);
      ts <= 14'($urandom % 16383);
    end
  endtask
  task sleepchk;
    begin
      repeat (2) @(negedge clk);
      chk(cr, cs);
      chk(st, 2'h0);
      repeat (3) @(negedge clk);
      chk(pwr, 1'b0);
      nxt;
    end
  endtask
  task results;
    begin
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    void'($urandom(32'hDF0D868F));
    {srst, sl, spi, ds, cm, cfg, res, rate, flt} = {1'b1, 12'h000};
    cs = 14'h0123;
    ts = 14'h0456;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk({rdy, st}, 3'h1);
    host.pulse(0);
    chk(st, 2'h1);
    for (int c = 0; c < 3; c++) begin
      @(posedge clk);
      // Corner 8-bit/00 first, then one random field per pass
      res <= (c == 2) ? 2'($urandom % 2) : 2'(c == 1);
      rate <= (c == 1) ? 2'($urandom % 2) : 2'(c == 2);
      ds <= 1'($urandom);
      // Config parity is only looked at on boot and wake
      cfg <= 1'($urandom);
      tv = 1'b0;
      wup;
      wup;
      for (int i = 0; i < 12; i++) begin
        nxt;
        wup;
        e = TK * (capt[res] + ratx[rate]);
        if (g > e + 6) begin
          e = e + TK * tmpx[res];
          t2 = t1;
          t1 = i;
          tx = ts;
          tv = 1'b1;
        end
        chk(g, e);
        repeat (2) @(negedge clk);
        if (tv) chk(tr, tx);
        chk(hb, {2'h0, cs[13:8]});
        if (i == 0) begin
          host.pulse(0);
          chk({rdy, st, cr}, {3'h1, cs});
        end
      end
      chk(16'(t1 - t2), 16'h0006);
    end
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      flt <= (3'h1 << k) | 3'($urandom);
      ds <= 1'b1;
      cfg <= 1'b0;
      wup;
      repeat (3) @(negedge clk);
      chk({cd, td, cr, tr}, 30'h3FFFFFFF);
      @(posedge clk);
      flt <= 3'h0;
      wup;
      wup;
      repeat (2) @(negedge clk);
      chk(cr, cs);
    end
    @(posedge clk);
    cm <= 1'b1;
    repeat (4) @(negedge clk);
    chk(st, 2'h2);
    @(posedge clk);
    cm <= 1'b0;
    sl <= 1'b1;
    repeat (3) @(negedge clk);
    chk(aen, 1'b0);
    @(posedge clk);
    ds <= 1'b0;
    // Let the cycle in flight finish before counting writes
    repeat (800) @(posedge clk);
    t1 = nw;
    repeat (400) @(negedge clk);
    chk({pwr, 16'(nw - t1)}, 17'h00000);
    host.pulse(1);
    wup;
    sleepchk;
    host.pulse(1);
    wup;
    sleepchk;
    @(posedge clk);
    spi <= 1'b1;
    t1 = nw;
    host.pulse(1);
    repeat (400) @(negedge clk);
    chk(16'(nw - t1), 16'h0000);
    host.pulse(0);
    host.pulse(1);
    wup;
    sleepchk;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      cfg <= (k == 0);
      host.pulse(0);
      host.pulse(1);
      wup;
      repeat (2) @(negedge clk);
      chk(cr, 14'h3FFF);
    end
    results;
  end
endmodule // testbench
